// >>> rtl/dpe_pkg.sv
// Shared constants and types for the debug port entry and capture block
package dpe_pkg;
  localparam int unsigned WORD_W      = 32;          // Data word width
  localparam int unsigned CMD_W       = 8;           // Serial command width
  localparam int unsigned RS_W        = 5;           // Register select width
  localparam int unsigned HIST_DEPTH  = 5;           // History entries
  localparam int unsigned HPTR_W      = 3;           // History pointer width
  localparam int unsigned BUF_DEPTH   = 16;          // Address buffer depth
  // Command field positions
  localparam int unsigned CMD_RW_BIT  = 7;           // Read when set
  localparam int unsigned CMD_GO_BIT  = 6;           // Execute instruction
  localparam int unsigned CMD_EX_BIT  = 5;           // Leave debug mode
  // Register select codes
  localparam logic [4:0] RS_XFER     = 5'h08;        // Transfer word
  localparam logic [4:0] RS_PDB      = 5'h09;        // Program data capture
  localparam logic [4:0] RS_FETCH    = 5'h0a;        // Fetch address capture
  localparam logic [4:0] RS_ILATCH   = 5'h0b;        // Instruction latch cap
  localparam logic [4:0] RS_HIST     = 5'h11;        // Address history
  localparam logic [4:0] RS_DECODE   = 5'h12;        // Decode address capture
  // Core X I/O address of the transfer word
  localparam logic [31:0] XFER_XIO_ADDR = 32'h0ffffff0;
  // Reset values
  localparam logic [31:0] WORD_RST    = 32'h00000000;
  localparam logic [2:0]  HPTR_RST    = 3'h0;
  // Acknowledge pulse length in core cycles
  localparam int unsigned ACK_CYCLES  = 1;
  // Synchroniser fill time before the reset strap is judged
  localparam logic [1:0]  STRAP_WAIT  = 2'h2;
  // Core-side debug state
  typedef enum logic [2:0] {
    DPE_ST_STRAP, DPE_ST_RUN, DPE_ST_PEND, DPE_ST_HALT, DPE_ST_GO
  } dpe_state_t;
  // Serial link phase
  typedef enum logic [1:0] {
    DPE_LK_CMD, DPE_LK_DATA, DPE_LK_TX
  } dpe_link_t;
endpackage

// >>> rtl/dpe_stream_if.sv
// Valid/ready stream carrier between the block's own modules
`timescale 1ns/1ns
interface dpe_stream_if #(parameter int unsigned W = 32);
  logic         valid;  // Word offered
  logic         ready;  // Word accepted
  logic [W-1:0] data;   // Word payload
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> rtl/dpe_fifo.sv
// Show-ahead FIFO buffering executed program addresses
`timescale 1ns/1ns
module dpe_fifo #(
  parameter int unsigned W     = 32,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  dpe_stream_if.snk wr,
  dpe_stream_if.src rd
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];   // Storage
  logic [AW-1:0] wp_q;           // Write index
  logic [AW-1:0] rp_q;           // Read index
  logic [AW:0]   cnt_q;          // Fill level
  wire           push = wr.valid && wr.ready;
  wire           pop  = rd.valid && rd.ready;
  wire           at_end_w = (wp_q == AW'(DEPTH - 1));
  wire           at_end_r = (rp_q == AW'(DEPTH - 1));

  // Honest full and empty
  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem_q[rp_q];

  // Storage write
  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      mem_q[wp_q] <= wr.data;
    end
  end

  // Pointers and level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (clk_en) begin
      if (push) wp_q <= at_end_w ? '0 : wp_q + 1'b1;
      if (pop)  rp_q <= at_end_r ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> rtl/dpe_debug_port.sv
// Debug serial port, debug entry control and pipeline capture
`timescale 1ns/1ns
module dpe_debug_port
  import dpe_pkg::*;
#(
  parameter int unsigned BUF_D = dpe_pkg::BUF_DEPTH
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  input  wire logic                      debug_serial_clk,
  input  wire logic                      debug_serial_in,
  input  wire logic                      debug_request_n,
  output logic                           debug_serial_out,
  input  wire logic                      ilatch_load,
  input  wire logic [dpe_pkg::WORD_W-1:0] ilatch_data,
  input  wire logic [dpe_pkg::WORD_W-1:0] decode_stage_address,
  input  wire logic [dpe_pkg::WORD_W-1:0] fetch_stage_address,
  input  wire logic                      pdb_valid,
  input  wire logic [dpe_pkg::WORD_W-1:0] program_data_bus,
  input  wire logic                      exec_done,
  input  wire logic                      exec_killed,
  input  wire logic [dpe_pkg::WORD_W-1:0] exec_address,
  output logic                           exec_ready,
  input  wire logic                      in_stop,
  input  wire logic                      in_wait,
  input  wire logic                      cond_debug_true,
  input  wire logic                      trace_zero,
  input  wire logic                      bkpt_enable,
  input  wire logic                      prog_bkpt_match,
  input  wire logic                      data_bkpt_match,
  input  wire logic                      xio_write,
  input  wire logic [dpe_pkg::WORD_W-1:0] xio_address,
  input  wire logic [dpe_pkg::WORD_W-1:0] xio_wdata,
  output logic                           debug_mode,
  output logic                           core_halt,
  output logic                           core_wake,
  output logic                           core_go,
  output logic [dpe_pkg::WORD_W-1:0]      pdb_restore
);
  import dpe_pkg::*;

  // Synchronisers for pins
  logic [1:0] sclk_s_q;              // Serial clock sync
  logic [1:0] sin_s_q;               // Serial data sync
  logic [1:0] req_s_q;               // Request sync
  logic       sclk_d1_q;             // Previous synced clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Serial clock idles low: match it so no false fall follows reset
      sclk_s_q  <= 2'h0;
      sin_s_q   <= 2'h0;
      req_s_q   <= 2'h3;
      sclk_d1_q <= 1'b0;
    end else if (clk_en) begin
      sclk_s_q  <= {sclk_s_q[0], debug_serial_clk};
      sin_s_q   <= {sin_s_q[0], debug_serial_in};
      req_s_q   <= {req_s_q[0], debug_request_n};
      sclk_d1_q <= sclk_s_q[1];
    end
  end
  wire sclk_fall = sclk_d1_q && !sclk_s_q[1];        // Falling edge seen
  wire req_on    = !req_s_q[1];                      // Request asserted
  wire sin_bit   = sin_s_q[1];                       // Synced data bit

  // State registers
  dpe_state_t  st_q;                 // Debug state
  dpe_link_t   lk_q;                 // Link phase
  logic [1:0]  strap_cnt_q;          // Strap wait counter
  logic        data_bp_q;            // Data breakpoint armed
  logic        ack_q;                // Acknowledge pulse
  logic [5:0]  bit_cnt_q;            // Bits left in phase
  logic [CMD_W-1:0]  cmd_q;          // Last command
  logic [WORD_W-1:0] rx_q;           // Receive shifter
  logic [WORD_W-1:0] tx_q;           // Transmit shifter
  logic [WORD_W-1:0] xfer_q;         // Transfer word
  logic [WORD_W-1:0] pdb_cap_q;      // Program data capture
  logic [WORD_W-1:0] il_cap_q;       // Instruction latch capture
  logic [WORD_W-1:0] fa_cap_q;       // Fetch address capture
  logic [WORD_W-1:0] da_cap_q;       // Decode address capture
  logic [WORD_W-1:0] hist_q [HIST_DEPTH]; // Address history
  logic [HPTR_W-1:0] hrd_q;          // History read pointer
  logic [HPTR_W-1:0] hwr_q;          // History write pointer

  // Address buffer between core and history
  dpe_stream_if #(.W(WORD_W)) buf_in ();
  dpe_stream_if #(.W(WORD_W)) buf_out ();
  dpe_fifo #(.W(WORD_W), .DEPTH(BUF_D)) u_fifo (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .wr      (buf_in.snk),
    .rd      (buf_out.src)
  );

  // Run-state decode
  wire running   = (st_q == DPE_ST_RUN) || (st_q == DPE_ST_PEND);
  wire halted    = (st_q == DPE_ST_HALT);
  wire executed  = exec_done && !exec_killed;
  // Only executed user instructions enter the history
  assign buf_in.valid = running && executed;
  assign buf_in.data  = exec_address;
  assign exec_ready   = buf_in.ready;

  // Immediate entry causes at instruction completion
  wire trace_hit = running && executed && trace_zero;
  wire pbp_hit   = running && executed && bkpt_enable
                   && prog_bkpt_match;
  wire dbp_hit   = running && executed && data_bp_q;
  wire done_hit  = trace_hit || pbp_hit || dbp_hit;
  // Deferred causes wait for the next instruction latch load
  wire defer_req = req_on || (executed && cond_debug_true);
  wire pend_hit  = (st_q == DPE_ST_PEND) && ilatch_load;
  wire strap_hit = (st_q == DPE_ST_STRAP) && (strap_cnt_q == STRAP_WAIT)
                   && req_on;
  wire go_done   = (st_q == DPE_ST_GO) && exec_done;
  wire enter     = (running && (done_hit || pend_hit)) || strap_hit;

  // Serial command decode
  wire [RS_W-1:0] rs = cmd_q[RS_W-1:0];
  wire cmd_rd   = cmd_q[CMD_RW_BIT];
  wire cmd_go   = cmd_q[CMD_GO_BIT];
  wire cmd_ex   = cmd_q[CMD_EX_BIT];
  wire bit_last = (bit_cnt_q == 6'h01);
  wire cmd_end  = sclk_fall && (lk_q == DPE_LK_CMD) && bit_last;
  wire data_end = sclk_fall && (lk_q == DPE_LK_DATA) && bit_last;
  wire [CMD_W-1:0] cmd_new = {rx_q[CMD_W-2:0], sin_bit};
  wire [WORD_W-1:0] word_new = {rx_q[WORD_W-2:0], sin_bit};
  wire new_rd   = cmd_new[CMD_RW_BIT];
  // Commands act only while halted
  wire rd_start = cmd_end && halted && new_rd;
  wire wr_start = cmd_end && halted && !new_rd;
  wire wr_done  = data_end && halted;
  wire pdb_wr   = wr_done && (rs == RS_PDB);
  wire go_start = wr_done && cmd_go;
  wire ex_start = cmd_end && halted && cmd_new[CMD_EX_BIT]
                  && new_rd;
  wire ex_wr    = wr_done && cmd_ex && !cmd_go;
  wire hist_rd  = rd_start && (cmd_new[RS_W-1:0] == RS_HIST);
  wire [HPTR_W-1:0] hrd_nx = (hrd_q == HPTR_W'(HIST_DEPTH - 1))
                             ? HPTR_RST : hrd_q + 1'b1;
  wire [HPTR_W-1:0] hwr_nx = (hwr_q == HPTR_W'(HIST_DEPTH - 1))
                             ? HPTR_RST : hwr_q + 1'b1;
  // History drain stalls during a history read
  assign buf_out.ready = !hist_rd;
  wire hist_push = buf_out.valid && buf_out.ready;

  // Read data selection
  logic [WORD_W-1:0] rd_sel;
  wire [RS_W-1:0] rs_new = cmd_new[RS_W-1:0];
  assign rd_sel = (rs_new == RS_XFER)   ? xfer_q   :
                  (rs_new == RS_PDB)    ? pdb_cap_q :
                  (rs_new == RS_FETCH)  ? fa_cap_q :
                  (rs_new == RS_ILATCH) ? il_cap_q :
                  (rs_new == RS_HIST)   ? hist_q[hrd_q] :
                  (rs_new == RS_DECODE) ? da_cap_q : WORD_RST;

  // Debug state machine
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= DPE_ST_STRAP;
      strap_cnt_q <= 2'h0;
    end else if (clk_en) begin
      case (st_q)
        DPE_ST_STRAP: begin
          // Wait for synchronisers to fill before judging request
          if (strap_cnt_q != STRAP_WAIT) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
          end else begin
            st_q <= req_on ? DPE_ST_HALT : DPE_ST_RUN;
          end
        end
        DPE_ST_RUN: begin
          if (done_hit) begin
            st_q <= DPE_ST_HALT;
          end else if (defer_req) begin
            st_q <= DPE_ST_PEND;
          end
        end
        DPE_ST_PEND: begin
          if (done_hit || ilatch_load) begin
            st_q <= DPE_ST_HALT;
          end
        end
        DPE_ST_HALT: begin
          if (go_start) begin
            st_q <= DPE_ST_GO;
          end else if (ex_start || ex_wr) begin
            st_q <= DPE_ST_RUN;
          end
        end
        DPE_ST_GO: begin
          if (exec_done) begin
            st_q <= cmd_ex ? DPE_ST_RUN : DPE_ST_HALT;
          end
        end
        default: st_q <= DPE_ST_RUN;
      endcase
    end
  end

  // Data breakpoint is armed by a match and fires one instruction later
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_bp_q <= 1'b0;
    end else if (clk_en) begin
      if (!running || dbp_hit) data_bp_q <= 1'b0;
      else if (executed && bkpt_enable && data_bkpt_match)
        data_bp_q <= 1'b1;
    end
  end

  // Acknowledge pulse on entry and on each finished command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else if (clk_en) begin
      ack_q <= enter || go_done || (wr_done && !go_start)
               || rd_start;
    end
  end

  // Serial link: receive on falling edge, shift out after it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lk_q      <= DPE_LK_CMD;
      bit_cnt_q <= 6'(CMD_W);
      cmd_q     <= 8'hff;
      rx_q      <= WORD_RST;
      tx_q      <= WORD_RST;
    end else if (clk_en && sclk_fall) begin
      case (lk_q)
        DPE_LK_CMD: begin
          rx_q      <= word_new;
          bit_cnt_q <= bit_last ? 6'(WORD_W) : bit_cnt_q - 6'h01;
          if (bit_last) begin
            cmd_q <= cmd_new;
            tx_q  <= rd_sel;
            lk_q  <= rd_start ? DPE_LK_TX :
                     wr_start ? DPE_LK_DATA : DPE_LK_CMD;
            if (!rd_start && !wr_start) bit_cnt_q <= 6'(CMD_W);
          end
        end
        DPE_LK_DATA: begin
          rx_q      <= word_new;
          bit_cnt_q <= bit_last ? 6'(CMD_W) : bit_cnt_q - 6'h01;
          if (bit_last) lk_q <= DPE_LK_CMD;
        end
        DPE_LK_TX: begin
          tx_q      <= {tx_q[WORD_W-2:0], 1'b0};
          bit_cnt_q <= bit_last ? 6'(CMD_W) : bit_cnt_q - 6'h01;
          if (bit_last) lk_q <= DPE_LK_CMD;
        end
        default: lk_q <= DPE_LK_CMD;
      endcase
    end
  end

  // Pipeline captures
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pdb_cap_q <= WORD_RST;
      il_cap_q  <= WORD_RST;
      fa_cap_q  <= WORD_RST;
      da_cap_q  <= WORD_RST;
    end else if (clk_en) begin
      if (running && pdb_valid) pdb_cap_q <= program_data_bus;
      else if (pdb_wr) pdb_cap_q <= word_new;
      if (running && enter) begin
        il_cap_q <= ilatch_data;
        fa_cap_q <= fetch_stage_address;
        da_cap_q <= decode_stage_address;
      end else if (pdb_wr) begin
        il_cap_q <= word_new;
      end
    end
  end

  // Transfer word written by the core
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_q <= WORD_RST;
    end else if (clk_en && xio_write && xio_address == XFER_XIO_ADDR) begin
      xfer_q <= xio_wdata;
    end
  end

  // History ring and pointers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrd_q <= HPTR_RST;
      hwr_q <= HPTR_RST;
      for (int i = 0; i < HIST_DEPTH; i++) hist_q[i] <= WORD_RST;
    end else if (clk_en) begin
      if (hist_push) begin
        hist_q[hwr_q] <= buf_out.data;
        hwr_q <= hwr_nx;
        hrd_q <= hwr_nx;
      end else if (hist_rd) begin
        hrd_q <= hrd_nx;
      end
    end
  end

  // Core-facing outputs
  assign debug_mode = halted || (st_q == DPE_ST_GO);
  assign core_halt  = halted || (st_q == DPE_ST_STRAP);
  assign core_wake  = req_on && (in_stop || in_wait) && running;
  assign core_go    = go_start;
  assign pdb_restore = pdb_cap_q;
  assign debug_serial_out = ack_q ? 1'b0 :
                            (lk_q == DPE_LK_TX) ? tx_q[WORD_W-1] : 1'b1;

  // Checks
  AST_ENTRY_ACK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && enter |=> !debug_serial_out && debug_mode)
    else $error("entry not acknowledged");
  AST_ACK_SHORT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && ack_q && !$past(ack_q) && !(enter || go_done || rd_start)
    |=> !ack_q)
    else $error("acknowledge too long");
  AST_STRAP_NOFETCH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q == DPE_ST_STRAP |-> core_halt && !core_go)
    else $error("core ran before strap judged");
  AST_PEND_LATCH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && st_q == DPE_ST_PEND && ilatch_load |=> halted)
    else $error("no halt after latch load");
  AST_PBP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && running && exec_done && !exec_killed && bkpt_enable
    && prog_bkpt_match |=> halted && !debug_serial_out)
    else $error("program breakpoint missed");
  AST_DBP_LATER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && st_q == DPE_ST_RUN && executed && bkpt_enable
    && data_bkpt_match && !done_hit && !defer_req |=> data_bp_q)
    else $error("data breakpoint not armed");
  AST_KILLED_NO_TRACE: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    clk_en && st_q == DPE_ST_RUN && exec_killed && !defer_req
    |=> st_q == DPE_ST_RUN)
    else $error("killed instruction entered debug");
  AST_FETCH_FROZEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    debug_mode && $past(debug_mode) |-> $stable(fa_cap_q)
    && $stable(da_cap_q))
    else $error("address capture changed in debug");
  AST_HIST_PTR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && hist_rd |=> hrd_q == (($past(hrd_q) == 3'h4) ? 3'h0
    : $past(hrd_q) + 3'h1))
    else $error("history pointer wrong");
  AST_PDB_COPY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && pdb_wr |=> il_cap_q == pdb_cap_q)
    else $error("latch capture not restored");
endmodule

// >>> tb/dpe_ctrl_model.sv
// Serial command controller model driving the debug link
`timescale 1ns/1ns
module dpe_ctrl_model (
  input  wire logic sys_clk,
  input  wire logic debug_serial_out,
  output logic      debug_serial_clk,
  output logic      debug_serial_in
);
  int unsigned ack_miss;  // Acknowledges that never came
  logic        r;         // Bit seen at the last rise
  // Link parked low between frames
  initial begin
    debug_serial_clk = 1'b0;
    debug_serial_in = 1'b0;
    ack_miss = 0;
  end
  // One 400 ns bit: output read at the rise, input held over the fall
  task automatic io(input logic b);
    #200 debug_serial_clk = 1'b1;
    r = debug_serial_out;
    #10 debug_serial_in = b;
    #190 debug_serial_clk = 1'b0;
  endtask
  // Command, data word if writing, acknowledge wait, read-out if reading
  task automatic xfer(input logic [7:0] c, input logic [31:0] d,
                      output logic [31:0] q);
    int k;
    for (int i = 7; i >= 0; i--) io(c[i]);
    if (!c[7]) for (int i = 31; i >= 0; i--) io(d[i]);
    for (k = 0; k < 800 && debug_serial_out !== 1'b0; k++) begin
      @(negedge sys_clk);
    end
    if (k == 800) ack_miss++;
    q = '0;
    if (c[7]) for (int i = 31; i >= 0; i--) begin
      io(~debug_serial_in);  // Unused input keeps toggling
      q[i] = r;
    end
  endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the debug port block
`timescale 1ns/1ns
module tb_top;
  import dpe_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n, debug_request_n, ilatch_load, pdb_valid;
  logic        exec_done, exec_killed, in_stop, in_wait, cond_debug_true;
  logic        trace_zero, bkpt_enable, prog_bkpt_match, data_bkpt_match;
  logic        xio_write;
  logic [31:0] ilatch_data, decode_stage_address, fetch_stage_address;
  logic [31:0] program_data_bus, exec_address, xio_address, xio_wdata;
  logic [31:0] q, v[5], h[6];
  wire         debug_serial_out, debug_serial_clk, debug_serial_in;
  wire         exec_ready, debug_mode, core_halt, core_wake, core_go;
  wire  [31:0] pdb_restore;
  int          error_cnt, samples_checked, k;
  localparam logic [4:0] SEL [5] = '{RS_XFER, RS_PDB, RS_FETCH,
                                      RS_DECODE, RS_ILATCH};
  dpe_debug_port u_dut (.sys_clk, .rst_n, .clk_en(1'b1), .debug_serial_clk,
    .debug_serial_in, .debug_request_n, .debug_serial_out, .ilatch_load,
    .ilatch_data, .decode_stage_address, .fetch_stage_address, .pdb_valid,
    .program_data_bus, .exec_done, .exec_killed, .exec_address, .exec_ready,
    .in_stop, .in_wait, .cond_debug_true, .trace_zero, .bkpt_enable,
    .prog_bkpt_match, .data_bkpt_match, .xio_write, .xio_address,
    .xio_wdata, .debug_mode, .core_halt, .core_wake, .core_go, .pdb_restore);
  dpe_ctrl_model u_m (.sys_clk, .debug_serial_out, .debug_serial_clk,
    .debug_serial_in);
  always #25 sys_clk = ~sys_clk;
  // Compare and count
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Counts and verdict
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One completed instruction; f = killed, trace, prog, data, cond
  task automatic ex(input logic [31:0] a, input logic [4:0] f);
    // Let an edge pass so back-to-back calls never re-drive in one step
    @(negedge sys_clk);
    while (exec_ready !== 1'b1) @(negedge sys_clk);
    {exec_done, exec_address} = {1'b1, a};
    {exec_killed, trace_zero, prog_bkpt_match, data_bkpt_match,
     cond_debug_true} = f;
    @(negedge sys_clk) {exec_done, exec_killed, trace_zero} = '0;
    {prog_bkpt_match, data_bkpt_match, cond_debug_true} = '0;
  endtask
  // Entry with low acknowledge within eight cycles
  task automatic ent;
    logic a;
    a = 1'b0;
    // Look first: the one-cycle pulse may already stand on entry
    repeat (8) begin
      if (debug_serial_out === 1'b0) a = 1'b1;
      @(negedge sys_clk);
    end
    chk(32'({debug_mode, a}), 32'h3);
  endtask
  // Still running a few cycles later
  task automatic no;
    repeat (3) @(negedge sys_clk);
    chk(32'(debug_mode), 32'h0);
  endtask
  // Exit by reading an unmapped select with the exit bit
  task automatic leave;
    u_m.xfer(8'hbf, 32'h0, q);
    chk(q, 32'h0);
    repeat (4) @(negedge sys_clk);
    chk(32'(debug_mode), 32'h0);
  endtask
  initial begin
    #2_000_000 error_cnt++;
    close_out();
  end
  initial begin
    {rst_n, debug_request_n, ilatch_load, pdb_valid} = '0;
    {exec_done, exec_killed, in_stop, in_wait, cond_debug_true} = '0;
    {trace_zero, prog_bkpt_match, data_bkpt_match, xio_write} = '0;
    {ilatch_data, decode_stage_address, fetch_stage_address} = '0;
    {program_data_bus, exec_address, xio_address, xio_wdata} = '0;
    {error_cnt, samples_checked} = '0;
    bkpt_enable = 1'b1;
    k = $urandom(32'h133e9198);
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    ent();
    chk(32'(core_halt), 32'h1);
    debug_request_n = 1'b1;
    leave();
    $display("test reset entry done");
    foreach (v[i]) v[i] = $urandom;
    foreach (h[i]) h[i] = $urandom;
    {xio_write, xio_address, xio_wdata} = {1'b1, XFER_XIO_ADDR, v[0]};
    @(negedge sys_clk) xio_address = XFER_XIO_ADDR + 32'h4;
    xio_wdata = ~v[0];
    {pdb_valid, program_data_bus} = {1'b1, v[1]};
    @(negedge sys_clk) {xio_write, pdb_valid} = '0;
    for (int i = 0; i < 5; i++) ex(h[i], 5'h00);
    ex($urandom, 5'h10);
    {fetch_stage_address, decode_stage_address} = {v[2], v[3]};
    ilatch_data = v[4];
    ex(h[5], 5'h04);
    ent();
    {fetch_stage_address, decode_stage_address, ilatch_data} = '1;
    for (int i = 0; i < 5; i++) begin
      u_m.xfer({3'b100, SEL[i]}, 32'h0, q);
      chk(q, v[i]);
    end
    for (int i = 0; i < 10; i++) begin
      u_m.xfer({3'b100, RS_HIST}, 32'h0, q);
      chk(q, h[1 + i % 5]);
    end
    $display("test capture and history done");
    v[0] = $urandom;
    fork
      u_m.xfer({3'b010, RS_PDB}, v[0], q);
      begin
        for (k = 0; k < 900 && core_go !== 1'b1; k++) @(negedge sys_clk);
        ex($urandom, 5'h00);
      end
    join
    chk(pdb_restore, v[0]);
    u_m.xfer({3'b100, RS_ILATCH}, 32'h0, q);
    chk(q, v[0]);
    leave();
    $display("test restore done");
    for (int c = 0; c < 6; c++) begin
      case (c)
        0: ex($urandom, 5'h04);
        1: begin ex($urandom, 5'h18); no(); ex($urandom, 5'h08); end
        2: begin ex($urandom, 5'h02); no(); ex($urandom, 5'h00); end
        default: begin
          if (c == 4) ex($urandom, 5'h01);
          else {debug_request_n, in_stop, in_wait} = {1'b0, c == 3, c == 5};
          no();
          if (c != 4) chk(32'(core_wake), 32'h1);
          {in_stop, in_wait, ilatch_load} = 3'b001;
          @(negedge sys_clk) ilatch_load = 1'b0;
        end
      endcase
      ent();
      debug_request_n = 1'b1;
      leave();
      $display("test cause %0d done", c);
    end
    chk(32'(u_m.ack_miss), 32'h0);
    close_out();
  end
endmodule
